// ---- rtl/lnb_pkg.sv ----
// Types shared by the two-wire slave port.
// Assumes nothing beyond a SystemVerilog compiler.
package lnb_pkg;

  // Phase of the byte sequence on the link.
  typedef enum logic [2:0] {
    st_addr,
    st_reg,
    st_data,
    st_read,
    st_ignore
  } link_state_t;

endpackage

// ---- rtl/lnb_regs.svh ----
// Constants of the two-wire slave port of the feed supply regulator.
// Assumes the including file uses these names with a leading backtick.
`ifndef LNB_REGS_SVH
`define LNB_REGS_SVH

// Chip address pattern and the single register address.
`define CHIP_ADDR_FIXED 5'h02
`define REG_ADDR_ZERO 8'h00
`define CTRL_REG_OFFSET 8'h00
`define STAT_REG_OFFSET 8'h00

// Control register layout and reset value.
`define CTRL_RESET 8'h00
`define CTRL_LEVEL_LSB 0
`define CTRL_LEVEL_MSB 2
`define CTRL_ON_BIT 3

// Status register layout.
`define STAT_SUPPLY_LOW 0
`define STAT_OVERCURRENT 1
`define STAT_OVERTEMP 2
`define STAT_POWER_BAD 3
`define STAT_RESET 8'h00

// Index of the last data bit of a byte on the link and the index of the acknowledge slot.
`define BYTE_LAST_BIT 4'h7
`define ACK_SLOT 4'h8

`endif

// ---- rtl/lnb_regulator_serial_slave.sv ----
// Two-wire slave port giving access to the control and status bytes.
// Assumes an external pull-up on the data and interrupt lines, and that
// the link clock pin is the master's serial clock, stopped between frames.
`timescale 1ns/1ps
`include "lnb_regs.svh"
module lnb_regulator_serial_slave (
  input wire logic clk, // System clock, 250 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable for the system domain.
  input wire logic scl_clk, // Serial clock from the master.
  input wire logic sda_in, // Serial data line level.
  output logic sda_out, // Serial data drive value.
  output logic sda_oe, // Serial data drive enable.
  input wire logic [1:0] addr_sel, // Address select pin level.
  input wire logic supply_low_in, // Undervoltage event.
  input wire logic overcurrent_in, // Overcurrent event.
  input wire logic overtemp_in, // Thermal shutdown event.
  input wire logic power_bad_in, // Power not good, live.
  output logic [2:0] output_level_select, // Output voltage level.
  output logic output_on, // Output enable.
  output logic irq_n_out, // Interrupt drive value.
  output logic irq_n_oe, // Interrupt drive enable.
  output logic [7:0] fault_status // Status byte as sent.
);
  import lnb_pkg::*;

  // System domain signals.
  logic [1:0] addr_sel_s;
  logic ack_tgl_s;
  logic ctrl_tgl_s;
  logic sda_s;
  logic scl_s;
  logic sda_prev;
  logic start_det;
  logic stop_det;
  logic link_rst_n;
  logic ack_seen;
  logic ctrl_seen;
  logic clear_pulse;
  logic ctrl_pulse;
  logic [7:0] output_control;
  logic [2:0] fault_latch;
  logic power_bad_q;
  logic [1:0] addr_sel_q;

  // Link domain signals.
  link_state_t state;
  link_state_t next_state;
  logic [3:0] bit_cnt;
  logic [7:0] rx;
  logic [7:0] byte_now;
  logic ack_pend;
  logic next_ack;
  logic [7:0] tx;
  logic [3:0] ctrl_shadow;
  logic ctrl_tgl;
  logic ack_tgl;
  logic [9:0] stat_m;
  logic [9:0] stat_s;
  logic [2:0] sent_faults;

  // System clock domain: pins, events, registers and outputs.

  // Pins and link toggles enter through three flops each.
  pin_sync #(
    .WIDTH(6),
    .RESET_VAL(6'h03)
  ) pin_sync_i (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .din({addr_sel, ack_tgl, ctrl_tgl, sda_in, scl_clk}),
    .dout({addr_sel_s, ack_tgl_s, ctrl_tgl_s, sda_s, scl_s})
  );

  // Start is data falling and stop is data rising, both with clock high.
  assign start_det = scl_s & sda_prev & ~sda_s;
  assign stop_det = scl_s & ~sda_prev & sda_s;

  // Remember the previous data level for edge detection.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_prev <= 1'b1;
    end else if (ce) begin
      sda_prev <= sda_s;
    end
  end

  // A start or stop resets the link sequence for one cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_rst_n <= 1'b0;
    end else if (ce) begin
      link_rst_n <= ~(start_det | stop_det);
    end
  end

  // Last seen level of the master acknowledge toggle from the link.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_seen <= 1'b0;
    end else if (ce) begin
      ack_seen <= ack_tgl_s;
    end
  end

  // Last seen level of the control store toggle from the link.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_seen <= 1'b0;
    end else if (ce) begin
      ctrl_seen <= ctrl_tgl_s;
    end
  end

  assign clear_pulse = ce & (ack_tgl_s ^ ack_seen);
  assign ctrl_pulse = ce & (ctrl_tgl_s ^ ctrl_seen);

  // The control byte is copied once the link has stored it; the
  // shadow is stable by then because the toggle passed three flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_control <= `CTRL_RESET;
    end else if (ctrl_pulse) begin
      output_control <= {4'h0, ctrl_shadow};
    end
  end

  // Faults latch on their event and clear only after an acknowledged
  // status read, and only those the read carried, so a fault that came
  // after the byte was taken is not lost. The sent copy has stood still
  // since the address acknowledge, long before the toggle arrives here.
  // A new event in the clearing cycle wins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_latch <= 3'h0;
    end else if (ce) begin
      fault_latch <= (fault_latch & ~({3{clear_pulse}} & sent_faults))
        | {overtemp_in, overcurrent_in, supply_low_in};
    end
  end

  // Power not good is reported live and never latched.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_bad_q <= 1'b0;
    end else if (ce) begin
      power_bad_q <= power_bad_in;
    end
  end

  // Address select level held for the link domain.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_sel_q <= 2'h0;
    end else if (ce) begin
      addr_sel_q <= addr_sel_s;
    end
  end

  // Status byte follows the latched faults and the live power flag.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_status <= `STAT_RESET;
    end else if (ce) begin
      fault_status <= `STAT_RESET;
      fault_status[`STAT_SUPPLY_LOW] <= fault_latch[0];
      fault_status[`STAT_OVERCURRENT] <= fault_latch[1];
      fault_status[`STAT_OVERTEMP] <= fault_latch[2];
      fault_status[`STAT_POWER_BAD] <= power_bad_q;
    end
  end

  // Interrupt line is pulled while any fault stays latched.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_n_oe <= 1'b0;
    end else if (ce) begin
      irq_n_oe <= |fault_latch;
    end
  end

  // The output obeys its enable only while no fault is latched.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_level_select <= 3'h0;
      output_on <= 1'b0;
    end else if (ce) begin
      output_level_select <= output_control[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB];
      output_on <= output_control[`CTRL_ON_BIT] & ~(|fault_latch);
    end
  end

  // Open-drain lines only ever pull low; the pull-up gives the high.
  assign irq_n_out = 1'b0;
  assign sda_out = 1'b0;

  // Link clock domain: shifters, sequence and data drive.

  // Status and address select cross as levels through two flops.
  // They settle over the address bytes, long before they are used.
  always_ff @(negedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      stat_m <= 10'h000;
      stat_s <= 10'h000;
    end else begin
      stat_m <= {addr_sel_q, fault_status};
      stat_s <= stat_m;
    end
  end

  // Byte as it stands after the bit being sampled now.
  assign byte_now = {rx[6:0], sda_in};

  // Acknowledge decision made on the eighth bit of each byte.
  always_comb begin
    next_ack = 1'b0;
    case (state)
      st_addr: begin
        next_ack = (byte_now[7:3] == `CHIP_ADDR_FIXED)
          && (byte_now[2:1] == stat_s[9:8]);
      end
      st_reg: begin
        next_ack = (byte_now == `REG_ADDR_ZERO);
      end
      st_data: begin
        next_ack = 1'b1;
      end
      default: begin
        next_ack = 1'b0;
      end
    endcase
  end

  // Sequence step taken at the acknowledge slot.
  always_comb begin
    next_state = st_ignore;
    case (state)
      st_addr: begin
        if (!ack_pend) begin
          next_state = st_ignore;
        end else if (rx[0]) begin
          next_state = st_read;
        end else begin
          next_state = st_reg;
        end
      end
      st_reg: begin
        next_state = ack_pend ? st_data : st_ignore;
      end
      default: begin
        next_state = st_ignore;
      end
    endcase
  end

  // Bit counter: eight data slots, then the acknowledge slot.
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= 4'h0;
    end else if (bit_cnt == `ACK_SLOT) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Receive shifter, sampled on the rising clock edge while data is stable.
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx <= 8'h00;
    end else if (bit_cnt != `ACK_SLOT) begin
      rx <= byte_now;
    end
  end

  // Acknowledge decision, held from the eighth bit through the ninth slot.
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_pend <= 1'b0;
    end else if (bit_cnt == `BYTE_LAST_BIT) begin
      ack_pend <= next_ack;
    end else if (bit_cnt == `ACK_SLOT) begin
      ack_pend <= 1'b0;
    end
  end

  // Sequence steps at the acknowledge slot; a start or stop restarts it.
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= st_addr;
    end else if (bit_cnt == `ACK_SLOT) begin
      state <= next_state;
    end
  end

  // Transmit shifter: status loaded at the address acknowledge, MSB first.
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx <= 8'h00;
    end else if (bit_cnt != `ACK_SLOT) begin
      tx <= {tx[6:0], 1'b0};
    end else if (state == st_addr) begin
      tx <= stat_s[7:0];
    end
  end

  // Control data and master acknowledge leave the link as toggles.
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_shadow <= 4'h0;
      ctrl_tgl <= 1'b0;
      ack_tgl <= 1'b0;
      sent_faults <= 3'h0;
    end else if (bit_cnt == `ACK_SLOT) begin
      if (state == st_addr && next_state == st_read && link_rst_n) begin
        sent_faults <= {stat_s[`STAT_OVERTEMP], stat_s[`STAT_OVERCURRENT], stat_s[`STAT_SUPPLY_LOW]};
      end
      if (state == st_data && ack_pend && link_rst_n) begin
        ctrl_shadow <= rx[3:0];
        ctrl_tgl <= ~ctrl_tgl;
      end
      if (state == st_read && !sda_in && link_rst_n) begin
        ack_tgl <= ~ack_tgl;
      end
    end
  end

  // Data drive changes on the falling clock edge only: acknowledge in
  // the ninth slot, status bits in the read phase, released otherwise.
  always_ff @(negedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe <= 1'b0;
    end else if (bit_cnt == `ACK_SLOT) begin
      sda_oe <= ack_pend && state != st_read;
    end else if (state == st_read) begin
      sda_oe <= ~tx[7];
    end else begin
      sda_oe <= 1'b0;
    end
  end

endmodule

// ---- rtl/pin_sync.sv ----
// Three-stage synchroniser with an agreement filter.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic [WIDTH-1:0] din, // Asynchronous inputs.
  output logic [WIDTH-1:0] dout // Filtered synchronous outputs.
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Three flops; a new level counts once stages two and three agree.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      dout <= RESET_VAL;
    end else if (ce) begin
      meta <= din;
      stage2 <= meta;
      stage3 <= stage2;
      dout <= (stage2 & stage3) | (dout & (stage2 ^ stage3));
    end
  end

endmodule

// ---- testbench/lnb_monitor.sv ----
// Concurrent checks on the ports of the two-wire slave port.
// Assumes it is bound to the slave and sees only its ports.
`timescale 1ns/1ps
module lnb_monitor (
  input wire logic clk, // System clock.
  input wire logic rstn, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic scl_clk, // Serial clock.
  input wire logic sda_out, // Data drive value.
  input wire logic sda_oe, // Data drive enable.
  input wire logic overcurrent_in, // Overcurrent event.
  input wire logic power_bad_in, // Live power flag.
  input wire logic output_on, // Output enable.
  input wire logic irq_n_out, // Interrupt drive value.
  input wire logic irq_n_oe, // Interrupt drive enable.
  input wire logic [7:0] fault_status // Status byte.
);
  // All checks run on the system clock and stop during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_sda_drive_low: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  a_drive_clock_low: assert property ($rose(sda_oe) |-> !scl_clk)
    else $error("data pulled while clock high");
  a_fault_sets_bit: assert property (ce && overcurrent_in |-> ##[1:8] fault_status[1])
    else $error("overcurrent not latched");
  a_fault_raises_irq: assert property ((fault_status[2:0] != 3'h0) [*3] |-> irq_n_oe)
    else $error("interrupt not raised");
  a_irq_value_low: assert property (irq_n_out == 1'b0)
    else $error("interrupt drive value not low");
  a_output_masked: assert property (irq_n_oe [*3] |-> !output_on)
    else $error("output on with fault latched");
  a_power_bad_set: assert property ((ce && power_bad_in) [*8] |-> fault_status[3])
    else $error("power flag not shown");
  a_power_bad_clear: assert property ((ce && !power_bad_in) [*8] |-> !fault_status[3])
    else $error("power flag stuck");
  a_status_upper_zero: assert property (fault_status[7:4] == 4'h0)
    else $error("status upper bits set");
endmodule
bind lnb_regulator_serial_slave lnb_monitor lnb_monitor_i (.clk(clk), .rstn(rstn), .ce(ce),
  .scl_clk(scl_clk), .sda_out(sda_out), .sda_oe(sda_oe), .overcurrent_in(overcurrent_in),
  .power_bad_in(power_bad_in), .output_on(output_on), .irq_n_out(irq_n_out),
  .irq_n_oe(irq_n_oe), .fault_status(fault_status));

// ---- testbench/mst.sv ----
// Behavioural two-wire bus master with start, stop and byte tasks.
// Assumes a pull-up on the data line; the clock idles high between frames.
`timescale 1ns/1ps
module mst #(
  parameter int HP = 40
) (
  output logic scl, // Serial clock, driven by this master only.
  output logic sda_low, // High while the master pulls data low.
  input wire logic sda // Resolved data line.
);
  // Bus rests released with the clock high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit: data moves only while the clock is low.
  task bt(input logic b, output logic r);
    #5 sda_low = ~b;
    #(HP - 5) scl = 1'b1;
    #HP r = sda;
    scl = 1'b0;
  endtask
  // Start or repeated start: data falls with the clock high.
  task start();
    #5 sda_low = 1'b0;
    #(HP - 5) scl = 1'b1;
    #HP sda_low = 1'b1;
    #HP scl = 1'b0;
  endtask
  // Stop, then the bus free time.
  task stop();
    #5 sda_low = 1'b1;
    #(HP - 5) scl = 1'b1;
    #HP sda_low = 1'b0;
    #1300;
  endtask
  // Sends a byte MSB first and returns the acknowledge level.
  task bw(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bt(v[i], r);
    bt(1'b1, ack);
  endtask
  // Reads a byte MSB first, then acknowledges or not.
  task br(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1'b1, v[i]);
    bt(~mack, r);
  endtask
endmodule

// ---- testbench/test_lnb_regulator_serial_slave.sv ----
// Self-checking bench of the two-wire slave port.
// Assumes the master model mst and the bound checker.
`timescale 1ns/1ps
module test_lnb_regulator_serial_slave;
  logic clk, rstn = 1'b0, ce = 1'b1, pb = 1'b0;
  logic [2:0] ev = 3'h0, lvl;
  logic [1:0] sel = 2'h0;
  logic scl, m_low, sda_out, sda_oe, on, irq_out, irq_oe, a0, a1, a2, r;
  logic [7:0] fs, rd, d;
  int n_fail = 0, n_checks = 0, ctrl_m = 0, flt_m = 0;
  // Open-drain data line with a pull-up.
  wire sda = (sda_oe ? sda_out : 1'b1) & ~m_low;
  mst mst_i (.scl(scl), .sda_low(m_low), .sda(sda));
  lnb_regulator_serial_slave lnb_regulator_serial_slave_i (.clk(clk), .rstn(rstn), .ce(ce),
    .scl_clk(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(sel),
    .supply_low_in(ev[0]), .overcurrent_in(ev[1]), .overtemp_in(ev[2]), .power_bad_in(pb),
    .output_level_select(lvl), .output_on(on), .irq_n_out(irq_out), .irq_n_oe(irq_oe),
    .fault_status(fs));
  // System clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch.
  task chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Compares the outputs with the reference model.
  task outs();
    repeat (30) @(posedge clk);
    #1;
    chk({3'h0, irq_oe, on, lvl}, {3'h0, flt_m != 0, ctrl_m[3] && flt_m == 0, 3'(ctrl_m)});
    chk(fs, {4'h0, pb, 3'(flt_m)});
  endtask
  task acks(input logic [2:0] e);
    chk({5'h0, a0, a1, a2}, {5'h0, e});
  endtask
  task wr(input logic [6:0] ad, input logic [7:0] ra, dv);
    mst_i.start();
    mst_i.bw({ad, 1'b0}, a0);
    mst_i.bw(ra, a1);
    mst_i.bw(dv, a2);
    mst_i.stop();
  endtask
  task rds(input logic mack);
    mst_i.start();
    mst_i.bw({5'h02, sel, 1'b0}, a0);
    mst_i.bw(8'h00, a1);
    mst_i.stop();
    mst_i.start();
    mst_i.bw({5'h02, sel, 1'b1}, a2);
    mst_i.br(mack, rd);
    mst_i.stop();
  endtask
  // Prints the counts and the verdict.
  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #300000;
    n_fail++;
    $display("Error at %0t: timeout", $time);
    end_sim();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h004d));
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk);
    outs();
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      sel = 2'($urandom);
      d = {4'($urandom), 1'($urandom), 3'(i)};
      wr({5'h02, sel}, 8'h00, d);
      acks(3'h0);
      ctrl_m = d & 8'h0f;
      outs();
    end
    $display("write test done");
    wr({5'h03, sel}, 8'h00, 8'h0f);
    acks(3'h7);
    wr({5'h02, ~sel}, 8'h00, 8'h0f);
    acks(3'h7);
    wr({5'h02, sel}, 8'h01, 8'h0f);
    acks(3'h3);
    outs();
    $display("refusal test done");
    mst_i.start();
    mst_i.bw({5'h02, sel, 1'b0}, a0);
    mst_i.bw(8'h00, a1);
    repeat (4) mst_i.bt(1'b1, r);
    wr({5'h02, sel}, 8'h00, 8'h0d);
    acks(3'h0);
    ctrl_m = 'h0d;
    outs();
    $display("abort test done");
    // An event while the clock enable is low must not latch.
    ce = 1'b0;
    ev[2] = 1'b1;
    @(posedge clk);
    #1 ev[2] = 1'b0;
    ce = 1'b1;
    outs();
    $display("enable test done");
    for (int f = 0; f < 3; f++) begin
      pb = 1'(f);
      @(posedge clk);
      #1 ev[f] = 1'b1;
      @(posedge clk);
      #1 ev[f] = 1'b0;
      flt_m = 1 << f;
      outs();
      rds(1'b0);
      chk(rd, {4'h0, pb, 3'(flt_m)});
      outs();
      rds(1'b1);
      acks(3'h0);
      chk(rd, {4'h0, pb, 3'(flt_m)});
      flt_m = 0;
      outs();
    end
    $display("status test done");
    // A second reset in mid-run clears control and faults; the link works after it.
    ev[0] = 1'b1;
    flt_m = 1;
    outs();
    rstn = 1'b0;
    ev[0] = 1'b0;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    ctrl_m = 0;
    flt_m = 0;
    repeat (10) @(posedge clk);
    outs();
    wr({5'h02, sel}, 8'h00, 8'h0b);
    acks(3'h0);
    ctrl_m = 'h0b;
    outs();
    $display("second reset test done");
    end_sim();
  end
endmodule
